// ---- hdl/irea_map.svh ----
// register-free constants for the two-wire clock and eeprom slave
// Behaviour
// - single master drives every exchange; slaves answer
// - seven-bit addressing, one clock, one data wire
// - clock chip answers address 1101000
// - direction bit follows address: 1 read
// - clock write: index, data bytes, then stop
// - reads start after last accessed register
// - clock chip holds 56 scratch bytes
// - eeprom address is 1010 plus straps
// - eeprom byte write: control, 14-bit address, data
// - page write takes up to 64 bytes
// - pointer advances after each written byte
// - page write wraps inside its page
// - current read returns byte at pointer
// - random read: write address, then read
// - sequential read pointer wraps to zero
// - data and clock pins shared by both slaves
`ifndef IREA_MAP_SVH
`define IREA_MAP_SVH
`define IREA_RTC_ADDR     7'h68
`define IREA_EEP_PREFIX   4'ha
`define IREA_RTC_PTR_W    6
`define IREA_RTC_DEPTH    64
`define IREA_RTC_TIME_N   8
`define IREA_RTC_SCRATCH  56
`define IREA_EEP_PTR_W    14
`define IREA_EEP_DEPTH    16384
`define IREA_PAGE_W       6
`define IREA_PAGE_BYTES   64
`define IREA_BIT_LAST     3'h7
`define IREA_IDX_DATA     2'h3
`endif

// ---- hdl/irea_pkg.sv ----
// types shared by the two-wire clock and eeprom slave
package irea_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK
  } irea_state_e;

  typedef struct packed {
    logic o;
    logic oe;
  } irea_pad_s;

  typedef struct packed {
    logic two;
    logic one;
    logic zero;
  } irea_strap_s;
endpackage

// ---- hdl/irea_top.sv ----
// two-wire slave holding the clock register file and the eeprom array
`timescale 1ns/10ps
`default_nettype none
`include "irea_map.svh"
module irea_top (
  // system
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  // two-wire bus, shared by both slaves
  input  wire logic                i_link_scl,
  input  wire logic                i_sda_i,
  output var  irea_pkg::irea_pad_s o_sda,
  // eeprom chip-select straps
  input  wire logic                i_chip_select_bit_two,
  input  wire logic                i_chip_select_bit_one,
  input  wire logic                i_chip_select_bit_zero,
  // status
  output logic                     o_frame_active
);
  import irea_pkg::*;

  function automatic logic [5:0] irea_inc6(input logic [5:0] v);
    irea_inc6 = v + 6'h01;
  endfunction

  // ---------------- system clock domain ----------------
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic scl_meta_reg;
  logic scl_sync_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic sda_prev_reg;
  logic frame_rst_n_reg;
  logic frame_active_reg;
  logic stop_det;
  logic start_det;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= i_link_scl;
      scl_sync_reg <= scl_meta_reg;
      sda_meta_reg <= i_sda_i;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  // data edges while the clock line is high
  assign stop_det  = scl_sync_reg & sda_sync_reg & ~sda_prev_reg;
  assign start_det = scl_sync_reg & ~sda_sync_reg & sda_prev_reg;

  // stop ends the frame: pulse the link-side frame reset
  always_ff @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      frame_rst_n_reg  <= 1'b0;
      frame_active_reg <= 1'b0;
    end else begin
      frame_rst_n_reg <= ~stop_det;
      if (stop_det) begin
        frame_active_reg <= 1'b0;
      end else if (start_det) begin
        frame_active_reg <= 1'b1;
      end
    end
  end

  assign o_frame_active = frame_active_reg;

  // ---------------- link clock domain ----------------
  logic                        sda_rise_reg;
  irea_strap_s                 strap_meta_reg;
  irea_strap_s                 strap_sync_reg;
  irea_state_e                 st_reg;
  logic [2:0]                  bit_cnt_reg;
  logic [1:0]                  byte_idx_reg;
  logic [7:0]                  shift_reg;
  logic [7:0]                  tx_reg;
  logic                        oe_reg;
  logic                        sel_rtc_reg;
  logic                        rw_reg;
  logic [`IREA_RTC_PTR_W-1:0]  rtc_ptr_reg;
  logic [`IREA_EEP_PTR_W-1:0]  eep_ptr_reg;
  logic [5:0]                  eep_hi_reg;
  logic [7:0]                  rtc_mem_reg [0:`IREA_RTC_DEPTH-1];
  logic [7:0]                  eep_mem_reg [0:`IREA_EEP_DEPTH-1];

  always_ff @(posedge i_link_scl or negedge frame_rst_n_reg) begin
    if (!frame_rst_n_reg) begin
      sda_rise_reg   <= 1'b1; // stop re-arms the start detector
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
    end else begin
      sda_rise_reg   <= i_sda_i;
      strap_meta_reg <= '{two: i_chip_select_bit_two, one: i_chip_select_bit_one,
                          zero: i_chip_select_bit_zero};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  logic       start_now;
  logic       bit_in;
  logic [7:0] byte_full;
  logic       rx_done;
  logic       addr_rtc;
  logic       addr_eep;
  logic       data_byte;
  logic       rtc_idx_wr;
  logic       rtc_wr;
  logic       eep_hi_wr;
  logic       eep_lo_wr;
  logic       eep_wr;
  logic       ld;
  logic       ld_rtc;
  logic       ld_eep;
  logic [7:0] rd_byte;

  // data falling while the clock is high marks a (repeated) start
  assign start_now  = sda_rise_reg & ~i_sda_i;
  assign bit_in     = sda_rise_reg;
  assign byte_full  = {shift_reg[6:0], bit_in};
  assign rx_done    = (st_reg == ST_RX) && (bit_cnt_reg == `IREA_BIT_LAST) && !start_now;
  assign addr_rtc   = rx_done && (byte_idx_reg == 2'h0)
                      && (byte_full[7:1] == `IREA_RTC_ADDR);
  assign addr_eep   = rx_done && (byte_idx_reg == 2'h0)
                      && (byte_full[7:1] == {`IREA_EEP_PREFIX, strap_sync_reg});
  assign data_byte  = rx_done && (byte_idx_reg != 2'h0);
  assign rtc_idx_wr = data_byte && sel_rtc_reg && (byte_idx_reg == 2'h1);
  assign rtc_wr     = data_byte && sel_rtc_reg && (byte_idx_reg >= 2'h2);
  assign eep_hi_wr  = data_byte && !sel_rtc_reg && (byte_idx_reg == 2'h1);
  assign eep_lo_wr  = data_byte && !sel_rtc_reg && (byte_idx_reg == 2'h2);
  assign eep_wr     = data_byte && !sel_rtc_reg && (byte_idx_reg == `IREA_IDX_DATA);
  // load on address ack of a read, or on master ack of a byte
  assign ld         = !start_now && (((st_reg == ST_ACK) && rw_reg)
                      || ((st_reg == ST_MACK) && !bit_in));
  assign ld_rtc     = ld && sel_rtc_reg;
  assign ld_eep     = ld && !sel_rtc_reg;
  assign rd_byte    = sel_rtc_reg ? rtc_mem_reg[rtc_ptr_reg] : eep_mem_reg[eep_ptr_reg];

  // protocol engine: bits taken at the rise, pin driven from the fall
  always_ff @(negedge i_link_scl or negedge frame_rst_n_reg) begin
    if (!frame_rst_n_reg) begin
      st_reg       <= ST_IDLE;
      bit_cnt_reg  <= 3'h0;
      byte_idx_reg <= 2'h0;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'h00;
      oe_reg       <= 1'b0;
      sel_rtc_reg  <= 1'b0;
      rw_reg       <= 1'b0;
    end else if (start_now) begin
      st_reg       <= ST_RX;
      bit_cnt_reg  <= 3'h0;
      byte_idx_reg <= 2'h0;
      oe_reg       <= 1'b0;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
          oe_reg <= 1'b0;
        end
        ST_RX: begin
          shift_reg   <= byte_full;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == `IREA_BIT_LAST) begin
            if (byte_idx_reg == 2'h0) begin
              if (addr_rtc || addr_eep) begin
                sel_rtc_reg  <= addr_rtc;
                rw_reg       <= bit_in;
                oe_reg       <= 1'b1;
                st_reg       <= ST_ACK;
                byte_idx_reg <= 2'h1;
              end else begin
                st_reg <= ST_IDLE;
              end
            end else begin
              oe_reg <= 1'b1;
              st_reg <= ST_ACK;
              if (byte_idx_reg != `IREA_IDX_DATA) begin
                byte_idx_reg <= byte_idx_reg + 2'h1;
              end
            end
          end
        end
        ST_ACK: begin
          bit_cnt_reg <= 3'h0;
          if (rw_reg) begin
            tx_reg <= rd_byte;
            oe_reg <= ~rd_byte[7];
            st_reg <= ST_TX;
          end else begin
            oe_reg <= 1'b0;
            st_reg <= ST_RX;
          end
        end
        ST_TX: begin
          if (bit_cnt_reg == `IREA_BIT_LAST) begin
            oe_reg <= 1'b0;
            st_reg <= ST_MACK;
          end else begin
            tx_reg      <= {tx_reg[6:0], 1'b0};
            oe_reg      <= ~tx_reg[6];
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
          end
        end
        ST_MACK: begin
          bit_cnt_reg <= 3'h0;
          if (!bit_in) begin
            tx_reg <= rd_byte;
            oe_reg <= ~rd_byte[7];
            st_reg <= ST_TX;
          end else begin
            oe_reg <= 1'b0;
            st_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // pointers survive frames so reads resume after the last access
  always_ff @(negedge i_link_scl or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rtc_ptr_reg <= '0;
      eep_ptr_reg <= '0;
      eep_hi_reg  <= 6'h00;
    end else begin
      if (rtc_idx_wr) begin
        rtc_ptr_reg <= byte_full[5:0];
      end else if (rtc_wr || ld_rtc) begin
        rtc_ptr_reg <= irea_inc6(rtc_ptr_reg);
      end
      if (eep_hi_wr) begin
        eep_hi_reg <= byte_full[5:0];
      end
      if (eep_lo_wr) begin
        eep_ptr_reg <= {eep_hi_reg, byte_full};
      end else if (eep_wr) begin
        eep_ptr_reg <= {eep_ptr_reg[13:6], irea_inc6(eep_ptr_reg[5:0])};
      end else if (ld_eep) begin
        eep_ptr_reg <= eep_ptr_reg + 14'h0001;
      end
    end
  end

  // clock file (8 time registers then 56 scratch bytes) and eeprom array writes
  always_ff @(negedge i_link_scl) begin
    if (rtc_wr) begin
      rtc_mem_reg[rtc_ptr_reg] <= byte_full;
    end
    if (eep_wr) begin
      eep_mem_reg[eep_ptr_reg] <= byte_full;
    end
  end

  // open-drain data pin: only ever pulls low
  assign o_sda = '{o: 1'b0, oe: oe_reg};

  // ---------------- assertions ----------------
  property p_rtc_addr_ack;
    @(negedge i_link_scl) disable iff (!frame_rst_n_reg)
    addr_rtc |=> (st_reg == ST_ACK) && oe_reg && sel_rtc_reg;
  endproperty
  a_rtc_addr_ack: assert property (p_rtc_addr_ack) else $error("clock address not acked");

  property p_eep_addr_ack;
    @(negedge i_link_scl) disable iff (!frame_rst_n_reg)
    addr_eep |=> (st_reg == ST_ACK) && oe_reg && !sel_rtc_reg;
  endproperty
  a_eep_addr_ack: assert property (p_eep_addr_ack) else $error("eeprom address not acked");

  property p_dir_bit;
    @(negedge i_link_scl) disable iff (!frame_rst_n_reg)
    (addr_rtc || addr_eep) |=> rw_reg == $past(bit_in);
  endproperty
  a_dir_bit: assert property (p_dir_bit) else $error("direction bit not captured");

  property p_eep_addr_load;
    @(negedge i_link_scl) disable iff (!rst_sync_reg)
    eep_lo_wr |=> eep_ptr_reg == {$past(eep_hi_reg), $past(byte_full)};
  endproperty
  a_eep_addr_load: assert property (p_eep_addr_load) else $error("word address not loaded");

  property p_page_inc;
    @(negedge i_link_scl) disable iff (!rst_sync_reg)
    eep_wr |=> eep_ptr_reg[5:0] == $past(eep_ptr_reg[5:0]) + 6'h01;
  endproperty
  a_page_inc: assert property (p_page_inc) else $error("page pointer not advanced");

  property p_page_wrap;
    @(negedge i_link_scl) disable iff (!rst_sync_reg)
    eep_wr |=> eep_ptr_reg[13:6] == $past(eep_ptr_reg[13:6]);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page write left its page");

  property p_seq_wrap;
    @(negedge i_link_scl) disable iff (!rst_sync_reg)
    (ld_eep && (eep_ptr_reg == 14'h3fff)) |=> eep_ptr_reg == 14'h0000;
  endproperty
  a_seq_wrap: assert property (p_seq_wrap) else $error("read pointer did not wrap");

  property p_rtc_read;
    @(negedge i_link_scl) disable iff (!frame_rst_n_reg)
    ld_rtc |=> (tx_reg == $past(rd_byte)) && (oe_reg == !tx_reg[7]);
  endproperty
  a_rtc_read: assert property (p_rtc_read) else $error("read byte not from pointer");

  property p_tx_release;
    @(negedge i_link_scl) disable iff (!frame_rst_n_reg)
    ((st_reg == ST_TX) && (bit_cnt_reg == `IREA_BIT_LAST) && !start_now)
      |=> (st_reg == ST_MACK) && !oe_reg;
  endproperty
  a_tx_release: assert property (p_tx_release) else $error("pin not freed for master ack");

  property p_nack_end;
    @(negedge i_link_scl) disable iff (!frame_rst_n_reg)
    ((st_reg == ST_MACK) && bit_in && !start_now) |=> (st_reg == ST_IDLE) && !oe_reg;
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("read went on after nack");

  property p_stop_frame;
    @(posedge i_clk) disable iff (!rst_sync_reg)
    stop_det |=> !frame_rst_n_reg && !frame_active_reg;
  endproperty
  a_stop_frame: assert property (p_stop_frame) else $error("stop did not end frame");

  c_rtc_write: cover property (@(negedge i_link_scl) rtc_wr);
  c_page_roll: cover property (@(negedge i_link_scl) eep_wr && (eep_ptr_reg[5:0] == 6'h3f));
  c_seq_read: cover property (@(negedge i_link_scl) ld_eep && (st_reg == ST_MACK));
  c_nack: cover property (@(negedge i_link_scl) (st_reg == ST_MACK) && bit_in);
endmodule
`default_nettype wire

// ---- verif/irea_master_model.sv ----
// two-wire bus master model: drives the clock and pulls the data line low
`timescale 1ns/10ps
`default_nettype none
module irea_master_model (
  // bus
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda_oe
);
  localparam int HP = 24;

  // clock idles high, stands still between frames
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  // start, or repeated start from a low clock
  task automatic start();
    if (!o_scl) begin
      #(HP/2) o_sda_oe = 1'b0;
      #(HP/2) o_scl = 1'b1;
      #HP;
    end
    o_sda_oe = 1'b1;
    #HP o_scl = 1'b0;
  endtask

  task automatic put_bit(input logic b);
    #(HP/2) o_sda_oe = ~b;
    #(HP/2) o_scl = 1'b1;
    #HP o_scl = 1'b0;
  endtask

  // released line floats to the pull-up level
  task automatic get_bit(output logic b);
    #(HP/2) o_sda_oe = 1'b0;
    #(HP/2) o_scl = 1'b1;
    b = i_sda;
    #HP o_scl = 1'b0;
  endtask

  // msb first, then sample the receiver's ack
  task automatic wbyte(input logic [7:0] d, output logic ack_n);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(ack_n);
  endtask

  // nack after the last byte only, stop follows
  task automatic rbyte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(last);
  endtask

  task automatic stop();
    #(HP/2) o_sda_oe = 1'b1;
    #(HP/2) o_scl = 1'b1;
    #HP o_sda_oe = 1'b0;
    #100;
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_i2c_rtc_eeprom_access.sv ----
// testbench for the two-wire clock and eeprom slave
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_rtc_eeprom_access;
  import irea_pkg::*;
  localparam logic [6:0] RTC = 7'h68;
  localparam logic [6:0] EEP = 7'h55;
  logic      clk;
  logic      rst_n;
  logic      scl;
  logic      m_oe;
  wire logic sda;
  logic      act;
  logic [2:0] strap;
  irea_pad_s pad;
  int        failures;
  int        n_checks;

  assign sda = ~(m_oe | pad.oe);

  irea_top irea_top_inst (
    .i_clk                 (clk),
    .i_rst_n               (rst_n),
    .i_link_scl            (scl),
    .i_sda_i               (sda),
    .o_sda                 (pad),
    .i_chip_select_bit_two (strap[2]),
    .i_chip_select_bit_one (strap[1]),
    .i_chip_select_bit_zero(strap[0]),
    .o_frame_active        (act)
  );
  irea_master_model irea_master_model_inst (
    .i_sda   (sda),
    .o_scl   (scl),
    .o_sda_oe(m_oe)
  );

  always #5 clk = ~clk;

  task automatic print_verdict();
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp1(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %0t flag %b expected %b", $time, g, e);
    end
  endtask

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %0t byte %h expected %h", $time, g, e);
    end
  endtask

  task automatic open(input logic [6:0] a, input logic rw, input logic ack_n);
    logic k;
    irea_master_model_inst.start();
    irea_master_model_inst.wbyte({a, rw}, k);
    cmp1(k, ack_n);
  endtask

  task automatic wr(input logic [7:0] q[$]);
    logic k;
    foreach (q[i]) begin
      irea_master_model_inst.wbyte(q[i], k);
      cmp1(k, 1'b0);
    end
  endtask

  task automatic rd(input logic [7:0] q[$]);
    logic [7:0] d;
    foreach (q[i]) begin
      irea_master_model_inst.rbyte(i == q.size() - 1, d);
      cmp8(d, q[i]);
    end
  endtask

  // stop, then a bounded wait for the frame flag to drop
  task automatic fin();
    cmp1(act, 1'b1);
    irea_master_model_inst.stop();
    for (int n = 0; n < 20 && act !== 1'b0; n++) begin
      @(negedge clk);
    end
    cmp1(act, 1'b0);
    if (act !== 1'b0) begin
      print_verdict();
    end
  endtask

  // index wraps 63 -> 0, then read back from the index
  task automatic t_rtc();
    open(RTC, 1'b0, 1'b0);
    wr('{8'h3f, 8'ha1, 8'hb2, 8'hc3});
    fin();
    open(RTC, 1'b0, 1'b0);
    wr('{8'h3f});
    open(RTC, 1'b1, 1'b0);
    rd('{8'ha1, 8'hb2, 8'hc3});
    fin();
  endtask

  task automatic t_straps();
    open({4'ha, 3'h4}, 1'b0, 1'b1);
    fin();
    open({4'ha, 3'h1}, 1'b0, 1'b1);
    fin();
  endtask

  task automatic t_byte(input logic [13:0] a, input logic [7:0] d);
    open(EEP, 1'b0, 1'b0);
    wr('{{2'h0, a[13:8]}, a[7:0], d});
    fin();
  endtask

  task automatic t_random();
    t_byte(14'h1234, 8'h5a);
    open(EEP, 1'b0, 1'b0);
    wr('{8'h12, 8'h34});
    open(EEP, 1'b1, 1'b0);
    rd('{8'h5a});
    fin();
  endtask

  // 65 bytes: the last one lands on the page's first byte
  task automatic t_page();
    logic [7:0] q[$];
    q = '{8'h01, 8'h00};
    for (int i = 1; i <= 65; i++) begin
      q.push_back(8'(i));
    end
    open(EEP, 1'b0, 1'b0);
    wr(q);
    fin();
    open(EEP, 1'b0, 1'b0);
    wr('{8'h01, 8'h00});
    open(EEP, 1'b1, 1'b0);
    rd('{8'h41, 8'h02, 8'h03, 8'h04});
    fin();
    open(EEP, 1'b1, 1'b0);
    rd('{8'h05});
    fin();
  endtask

  task automatic t_top_wrap();
    t_byte(14'h3fff, 8'hee);
    t_byte(14'h0000, 8'h77);
    open(EEP, 1'b0, 1'b0);
    wr('{8'h3f, 8'hff});
    open(EEP, 1'b1, 1'b0);
    rd('{8'hee, 8'h77});
    fin();
  endtask

  initial begin
    #500000;
    failures++;
    $display("mismatch %0t run did not finish", $time);
    print_verdict();
  end

  initial begin
    clk      = 1'b0;
    rst_n    = 1'b0;
    strap    = 3'h5;
    failures = 0;
    n_checks = 0;
    repeat (20) @(negedge clk);
    cmp1(pad.oe, 1'b0);
    cmp1(pad.o, 1'b0);
    cmp1(act, 1'b0);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    t_rtc();
    t_straps();
    t_random();
    t_page();
    t_top_wrap();
    print_verdict();
  end
endmodule
`default_nettype wire
